// ===== hw/lcd_segment_frame_control_defines.vh
// Register map, field positions, reset values and timing counts for the segment LCD controller
`ifndef LCD_SEGMENT_FRAME_CONTROL_DEFINES_VH
`define LCD_SEGMENT_FRAME_CONTROL_DEFINES_VH

`define LCD_ADDR_CONFIG 8'h95
`define LCD_ADDR_CLOCK 8'h96
`define LCD_ADDR_PIN_EN_HI 8'h97
`define LCD_ADDR_POINTER 8'hAC
`define LCD_ADDR_DATA 8'hAE
`define LCD_ADDR_CONFIG_SEC 8'hB1
`define LCD_ADDR_PIN_EN_LO 8'hED

`define LCD_CFG_CLEAR_BIT 6
`define LCD_CFG_BASE_CLOCK_SEL_BIT 3
`define LCD_CFG_BIAS_BIT 2
`define LCD_CFG_MUX_MSB 1
`define LCD_CFG_MUX_LSB 0
`define LCD_CLK_FD_MSB 3
`define LCD_CLK_FD_LSB 0
`define LCD_SEC_FREEZE_BIT 0
`define LCD_SEC_SCREEN_MSB 3
`define LCD_SEC_SCREEN_LSB 2
`define LCD_PTR_WRITE_BIT 7
`define LCD_PTR_SCREEN_MSB 5
`define LCD_PTR_SCREEN_LSB 4
`define LCD_PTR_ADDR_MSB 3
`define LCD_PTR_ADDR_LSB 0
`define LCD_PIN_EN_HI_MASK 8'hFC
`define LCD_PIN_EN_LO_MASK 8'h0F
`define LCD_CFG_MASK 8'h0F
`define LCD_CLK_MASK 8'h0F
`define LCD_SEC_MASK 8'h0D
`define LCD_PTR_MASK 8'hBF

`define LCD_RESET_BYTE 8'h00
`define LCD_MUX_3COM 2'h2
`define LCD_MUX_4COM 2'h3
`define LCD_BANK_BYTES 15
`define LCD_LAST_ADDR 4'hE

`define LCD_SYS_CLK_HZ 40000000
`define LCD_FAST_CLK_HZ 2048
`define LCD_SLOW_CLK_HZ 128
// Half periods of the base clock, in system cycles, rounded down
`define LCD_FAST_HALF_CYC (`LCD_SYS_CLK_HZ / (2 * `LCD_FAST_CLK_HZ))
`define LCD_SLOW_HALF_CYC (`LCD_SYS_CLK_HZ / (2 * `LCD_SLOW_CLK_HZ))

`endif

// ===== hw/lcd_segment_frame_control.v
// Segment LCD controller: special-function registers, segment memory and frame timing
//
// Function
// - Bits 7..2 select segment pins 20..25
// - Bits 3..0 select segment pins 16..19
// - Pointer load with top bit writes memory
// - Pointer bits 5..4 select target screen
// - Pointer low nibble is byte address
// - Data register holds byte, resets zero
// - Three commons turn pin 28 into common
// - Four commons: pin 28 and 27 commons
// - Segments 0..15 active from reset
// - Shared segment pins enable independently
// - Clear bit zeroes all segment memory
// - Reset zeroes all segment memory
// - Bit 3 picks 2048 or 128 Hz
// - Clock, commons and rate field set timing
// - Waveform frequency is common advance rate
// - Fast clock offers sixteen frame rates, fifteen with three commons
// - Slow clock gives its coarser rate set
// - Polarity inverts at twice common frequency
// - Pointer load with top clear reads memory
// - Four banks of fifteen bytes each
// - Low nibble even segment, high odd
// - Freeze holds display while set; clear still zeroes it
`timescale 1ns/1ps
`include "lcd_segment_frame_control_defines.vh"

module lcd_segment_frame_control #(
  parameter FAST_HALF_CYC = `LCD_FAST_HALF_CYC,
  parameter SLOW_HALF_CYC = `LCD_SLOW_HALF_CYC
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  output reg [7:0] sfr_rdata,
  output reg [28:0] seg_pin_lcd,
  output reg [28:0] seg_drive,
  output reg [3:0] com_drive,
  output reg [3:0] com_active,
  output reg drive_polarity,
  output reg bias_sel,
  output reg frame_start
);

  localparam N_BYTES = `LCD_BANK_BYTES;

  reg [7:0] display_config_reg;
  reg [7:0] display_clock_reg;
  reg [7:0] display_config_secondary;
  reg [7:0] segment_pin_enable_hi;
  reg [7:0] segment_pin_enable_lo;
  reg [7:0] segment_memory_pointer;
  reg [7:0] segment_memory_data;
  reg [7:0] seg_mem [0:4*N_BYTES-1];
  reg [7:0] shown [0:N_BYTES-1];
  reg [17:0] half_cnt;
  reg [7:0] step_cnt;
  reg [1:0] com_idx;
  reg pol;
  reg [7:0] next_div;
  reg [28:0] seg_bits;
  reg [3:0] com_bits;
  wire [1:0] mux = display_config_reg[`LCD_CFG_MUX_MSB:`LCD_CFG_MUX_LSB];
  wire clk_slow = display_config_reg[`LCD_CFG_BASE_CLOCK_SEL_BIT];
  wire [3:0] fd = display_clock_reg[`LCD_CLK_FD_MSB:`LCD_CLK_FD_LSB];
  wire freeze = display_config_secondary[`LCD_SEC_FREEZE_BIT];
  wire [1:0] show_screen = display_config_secondary[`LCD_SEC_SCREEN_MSB:`LCD_SEC_SCREEN_LSB];
  wire [1:0] last_com = (mux == `LCD_MUX_4COM) ? 2'h3 : ((mux == `LCD_MUX_3COM) ? 2'h2 : 2'h1);
  wire [17:0] half_limit = clk_slow ? SLOW_HALF_CYC[17:0] - 18'h1 : FAST_HALF_CYC[17:0] - 18'h1;
  // Compare with >= so a switch to the faster clock never strands the counter above its limit
  wire half_tick = (half_cnt >= half_limit);
  wire step_done = half_tick && (step_cnt >= next_div - 8'h1);
  wire slot_end = step_done && pol;
  wire frame_end = slot_end && (com_idx == last_com);
  wire wr_ptr = sfr_wr && (sfr_addr == `LCD_ADDR_POINTER);
  wire [3:0] ptr_addr = sfr_wdata[`LCD_PTR_ADDR_MSB:`LCD_PTR_ADDR_LSB];
  wire [5:0] ptr_index = {2'h0, sfr_wdata[`LCD_PTR_SCREEN_MSB:`LCD_PTR_SCREEN_LSB]} * 6'd15 +
                         {2'h0, ptr_addr};
  wire ptr_in_range = (ptr_addr <= `LCD_LAST_ADDR);
  wire mem_clear = !reset_n || (sfr_wr && (sfr_addr == `LCD_ADDR_CONFIG) &&
                   sfr_wdata[`LCD_CFG_CLEAR_BIT]);
  integer i;

  // Common slot length in base-clock periods; polarity half-slots use the same count
  always @* begin
    next_div = 8'h01;
    if (!clk_slow) begin
      if (mux == `LCD_MUX_4COM || mux == `LCD_MUX_3COM) begin
        if (fd == 4'h0)
          next_div = 8'h40;
        else
          next_div = {2'h0, {1'b0, fd} + 5'h01, 1'b0}; // Five bits so code 15 gives 32, not 0
        if (mux == `LCD_MUX_3COM && fd == 4'h1)
          next_div = 8'h06; // Three-common rate saturates at the second code
      end else begin
        if (fd == 4'h0)
          next_div = 8'h80;
        else
          next_div = {1'h0, {1'b0, fd} + 5'h01, 2'h0};
      end
    end else begin
      if (fd == 4'hF)
        next_div = 8'h01;
      else if (fd == 4'h0)
        next_div = 8'h02;
      else if (mux == `LCD_MUX_4COM || mux == `LCD_MUX_3COM)
        next_div = 8'h04;
      else if (fd == 4'h1)
        next_div = 8'h04;
      else if (fd == 4'h2)
        next_div = 8'h06;
      else
        next_div = 8'h08;
    end
  end

  // Register file and segment memory access
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      display_config_reg <= `LCD_RESET_BYTE;
      display_clock_reg <= `LCD_RESET_BYTE;
      display_config_secondary <= `LCD_RESET_BYTE;
      segment_pin_enable_hi <= `LCD_RESET_BYTE;
      segment_pin_enable_lo <= `LCD_RESET_BYTE;
      segment_memory_pointer <= `LCD_RESET_BYTE;
      segment_memory_data <= `LCD_RESET_BYTE;
    end else if (sfr_wr) begin
      if (sfr_addr == `LCD_ADDR_CONFIG) begin
        // Clear bit is a strobe and never reads back as set
        display_config_reg <= sfr_wdata & `LCD_CFG_MASK;
      end else if (sfr_addr == `LCD_ADDR_CLOCK) begin
        display_clock_reg <= sfr_wdata & `LCD_CLK_MASK;
      end else if (sfr_addr == `LCD_ADDR_CONFIG_SEC) begin
        display_config_secondary <= sfr_wdata & `LCD_SEC_MASK;
      end else if (sfr_addr == `LCD_ADDR_PIN_EN_HI) begin
        // Low two bits are stored so software sees what it wrote
        segment_pin_enable_hi <= sfr_wdata;
      end else if (sfr_addr == `LCD_ADDR_PIN_EN_LO) begin
        segment_pin_enable_lo <= sfr_wdata & `LCD_PIN_EN_LO_MASK;
      end else if (sfr_addr == `LCD_ADDR_DATA) begin
        segment_memory_data <= sfr_wdata;
      end else if (sfr_addr == `LCD_ADDR_POINTER) begin
        segment_memory_pointer <= sfr_wdata & `LCD_PTR_MASK;
        if (!sfr_wdata[`LCD_PTR_WRITE_BIT])
          segment_memory_data <= ptr_in_range ? seg_mem[ptr_index] : `LCD_RESET_BYTE;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (mem_clear) begin
      for (i = 0; i < 4 * N_BYTES; i = i + 1)
        seg_mem[i] <= `LCD_RESET_BYTE;
    end else if (wr_ptr && sfr_wdata[`LCD_PTR_WRITE_BIT] && ptr_in_range) begin
      seg_mem[ptr_index] <= segment_memory_data;
    end
  end

  // Read data; reserved bits read zero except high pin enable bits 1..0, unmapped addresses read zero
  always @(posedge sys_clk) begin
    if (!reset_n)
      sfr_rdata <= `LCD_RESET_BYTE;
    else if (sfr_addr == `LCD_ADDR_CONFIG)
      sfr_rdata <= display_config_reg;
    else if (sfr_addr == `LCD_ADDR_CLOCK)
      sfr_rdata <= display_clock_reg;
    else if (sfr_addr == `LCD_ADDR_CONFIG_SEC)
      sfr_rdata <= display_config_secondary;
    else if (sfr_addr == `LCD_ADDR_PIN_EN_HI)
      sfr_rdata <= segment_pin_enable_hi;
    else if (sfr_addr == `LCD_ADDR_PIN_EN_LO)
      sfr_rdata <= segment_pin_enable_lo;
    else if (sfr_addr == `LCD_ADDR_POINTER)
      sfr_rdata <= segment_memory_pointer;
    else if (sfr_addr == `LCD_ADDR_DATA)
      sfr_rdata <= segment_memory_data;
    else
      sfr_rdata <= `LCD_RESET_BYTE;
  end

  // Timing chain: base half-period enable, polarity half-slots, common index
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      half_cnt <= 18'h0;
      step_cnt <= 8'h0;
      pol <= 1'b0;
      com_idx <= 2'h0;
    end else begin
      half_cnt <= half_tick ? 18'h0 : half_cnt + 18'h1;
      if (step_done) begin
        step_cnt <= 8'h0;
        pol <= ~pol;
        if (slot_end)
          // A mux change can leave the index past the last common; it wraps at the
          // next slot end so the common never moves without a polarity flip
          com_idx <= (com_idx >= last_com) ? 2'h0 : com_idx + 2'h1;
      end else if (half_tick) begin
        step_cnt <= step_cnt + 8'h1;
      end
    end
  end

  // Display copy is refreshed at frame boundaries while not frozen, and zeroed at once by clear or reset
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      for (i = 0; i < N_BYTES; i = i + 1)
        shown[i] <= `LCD_RESET_BYTE;
    end else if ((frame_end && !freeze) || mem_clear) begin
      for (i = 0; i < N_BYTES; i = i + 1)
        shown[i] <= mem_clear ? `LCD_RESET_BYTE : seg_mem[show_screen * N_BYTES + i];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 14; g = g + 1) begin : seg_pair
      always @* begin
        seg_bits[2*g] = shown[g][com_idx];
        seg_bits[2*g+1] = shown[g][{1'b1, com_idx}];
      end
    end
  endgenerate

  always @* begin
    seg_bits[28] = shown[14][com_idx];
    com_bits = 4'h0;
    com_bits[com_idx] = 1'b1;
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      seg_pin_lcd <= {13'h0000, 16'hFFFF};
      seg_drive <= 29'h0;
      com_drive <= 4'h0;
      com_active <= 4'h0;
      drive_polarity <= 1'b0;
      bias_sel <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      seg_pin_lcd[15:0] <= 16'hFFFF;
      seg_pin_lcd[19:16] <= segment_pin_enable_lo[3:0];
      seg_pin_lcd[25:20] <= segment_pin_enable_hi[7:2];
      seg_pin_lcd[26] <= 1'b0;
      seg_pin_lcd[27] <= (mux != `LCD_MUX_4COM);
      seg_pin_lcd[28] <= (mux != `LCD_MUX_3COM) && (mux != `LCD_MUX_4COM);
      seg_drive <= seg_bits ^ {29{pol}};
      com_drive <= com_bits ^ {4{pol}};
      com_active <= com_bits;
      drive_polarity <= pol;
      bias_sel <= display_config_reg[`LCD_CFG_BIAS_BIT];
      frame_start <= frame_end;
    end
  end

endmodule

// ===== tb/lcd_glass_model.sv
// Glass panel stand-in: nets drive polarity time over each frame
`timescale 1ns/1ps
module lcd_glass_model (
  input wire sys_clk,
  input wire reset_n,
  input wire drive_polarity,
  input wire frame_start,
  output reg signed [15:0] frame_bal
);
  reg signed [15:0] acc;
  wire signed [15:0] step = drive_polarity ? 16'sh1 : -16'sh1;
  // Charge left on the glass shows as a nonzero net per frame
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      acc <= 16'sh0;
      frame_bal <= 16'sh0;
    end else if (frame_start) begin
      frame_bal <= acc;
      acc <= step;
    end else begin
      acc <= acc + step;
    end
  end
endmodule

// ===== tb/lcd_segment_frame_control_assertions.sv
// Port-level checks for the segment LCD controller
`timescale 1ns/1ps
module lcd_segment_frame_control_assertions (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire [7:0] sfr_rdata,
  input wire [28:0] seg_pin_lcd,
  input wire [3:0] com_drive,
  input wire [3:0] com_active,
  input wire drive_polarity,
  input wire frame_start
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_LOW_SEGS: assert property (seg_pin_lcd[15:0] == 16'hFFFF)
    else $error("low pins lost segment use");
  AST_COM_XOR: assert property (com_drive == (com_active ^ {4{drive_polarity}}))
    else $error("common drive not inverted");
  AST_ONE_COM: assert property ($onehot0(com_active))
    else $error("more than one common");
  AST_ADV_FLIP: assert property ($changed(com_active) && $past(com_active) != 4'h0
    |-> $changed(drive_polarity)) else $error("common moved off inversion");
  AST_POL_HOLD: assert property ($changed(drive_polarity)
    |=> $stable(drive_polarity) [*4]) else $error("inversion too fast");
  AST_FS_PULSE: assert property (frame_start |=> !frame_start)
    else $error("frame start too long");
  AST_DATA_BACK: assert property (sfr_wr && sfr_addr == 8'hAE ##1 sfr_addr == 8'hAE
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("data readback");
  AST_BAD_PTR: assert property (sfr_wr && sfr_addr == 8'hAC && sfr_wdata == 8'h0F
    ##1 !sfr_wr ##1 sfr_addr == 8'hAE |=> sfr_rdata == 8'h00) else $error("bad address read");
  AST_LO_BACK: assert property (sfr_wr && sfr_addr == 8'hED ##1 sfr_addr == 8'hED
    |=> sfr_rdata == {4'h0, $past(sfr_wdata[3:0], 2)}) else $error("low enable readback");
  AST_HI_PINS: assert property (sfr_wr && sfr_addr == 8'h97 ##1 !sfr_wr [*2]
    |=> seg_pin_lcd[25:20] == $past(sfr_wdata[7:2], 3)) else $error("high pins");
  COV_FRAME: cover property (frame_start);
  COV_PTR_WR: cover property (sfr_wr && sfr_addr == 8'hAC && sfr_wdata[7]);
  COV_COM4: cover property (com_active == 4'h8);
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the segment LCD controller
`timescale 1ns/1ps
module testbench;
  reg sys_clk, reset_n, sfr_wr;
  reg [7:0] sfr_addr, sfr_wdata;
  wire [7:0] sfr_rdata;
  wire [28:0] seg_pin_lcd, seg_drive;
  wire [3:0] com_drive, com_active;
  wire drive_polarity, bias_sel, frame_start;
  wire signed [15:0] frame_bal;
  integer n_mismatch = 0;
  integer total_checks = 0;
  // Entries: config, rate field, frame period in cycles
  reg [31:0] rate_tbl [0:7] = '{32'h030F_0200, 32'h0301_0040, 32'h0000_0400, 32'h0201_0048,
    32'h0B0F_0028, 32'h0B00_0050, 32'h0A03_0078, 32'h0902_0078};
  lcd_segment_frame_control #(.FAST_HALF_CYC(2), .SLOW_HALF_CYC(5)) uut (.sys_clk,
    .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rdata, .seg_pin_lcd, .seg_drive,
    .com_drive, .com_active, .drive_polarity, .bias_sel, .frame_start);
  lcd_glass_model glass (.sys_clk, .reset_n, .drive_polarity, .frame_start, .frame_bal);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Strobe drops for a cycle so no signal is driven twice in one step
  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      sfr_addr <= a;
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk(sfr_rdata, e);
    end
  endtask
  task wait_fs(output integer n);
    begin
      n = 1;
      @(posedge sys_clk);
      while (frame_start !== 1'b1 && n < 2000) begin
        @(posedge sys_clk);
        n = n + 1;
      end
    end
  endtask
  task wait2;
    integer n;
    begin
      wait_fs(n);
      wait_fs(n);
    end
  endtask
  task show(input [1:0] e);
    integer i;
    begin
      for (i = 0; i < 500 && com_active !== 4'h1; i++) @(posedge sys_clk);
      chk(seg_drive[1:0] ^ {2{drive_polarity}}, e);
    end
  endtask
  task t_reset;
    begin
      chk(seg_pin_lcd, 29'h0000FFFF);
      rd(8'h97, 8'h00);
      rd(8'hED, 8'h00);
      rd(8'hAE, 8'h00);
      rd(8'h10, 8'h00);
      $display("reset test done");
    end
  endtask
  task t_pins;
    begin
      wr(8'h97, 8'hA8);
      wr(8'hED, 8'hF5);
      repeat (3) @(posedge sys_clk);
      chk(seg_pin_lcd[25:16], 10'h2A5);
      rd(8'hED, 8'h05);
      rd(8'h97, 8'hA8);
      $display("pin test done");
    end
  endtask
  task t_mux;
    integer m;
    begin
      for (m = 0; m < 4; m++) begin
        wr(8'h95, 8'h04 | m[7:0]);
        repeat (3) @(posedge sys_clk);
        chk(seg_pin_lcd[28:27], m == 2 ? 2'b01 : m == 3 ? 2'b00 : 2'b11);
        chk(bias_sel, 1'b1);
      end
      $display("mux test done");
    end
  endtask
  task t_mem;
    integer s;
    begin
      for (s = 0; s < 4; s++) begin
        wr(8'hAE, 8'hA0 | s[7:0]);
        wr(8'hAC, 8'h8E | {2'b0, s[1:0], 4'h0});
      end
      for (s = 0; s < 4; s++) begin
        wr(8'hAC, 8'h0E | {2'b0, s[1:0], 4'h0});
        rd(8'hAE, 8'hA0 | s[7:0]);
      end
      wr(8'hAE, 8'h55);
      wr(8'hAC, 8'h8F);
      wr(8'hAC, 8'h0F);
      rd(8'hAE, 8'h00);
      wr(8'h95, 8'h43);
      wr(8'hAC, 8'h3E);
      rd(8'hAE, 8'h00);
      rd(8'h95, 8'h03);
      $display("memory test done");
    end
  endtask
  task t_rate;
    integer k, n;
    begin
      for (k = 0; k < 8; k++) begin
        wr(8'h95, rate_tbl[k][31:24]);
        wr(8'h96, rate_tbl[k][23:16]);
        wait2;
        wait_fs(n);
        chk(n, rate_tbl[k][15:0]);
        @(posedge sys_clk);
        chk(frame_bal, 32'h0);
      end
      $display("rate test done");
    end
  endtask
  task t_disp;
    begin
      wr(8'h95, 8'h0B);
      wr(8'h96, 8'h0F);
      wr(8'hB1, 8'h00);
      wr(8'hAE, 8'h01);
      wr(8'hAC, 8'h80);
      wait2;
      show(2'b01);
      wr(8'hB1, 8'h01);
      wr(8'hAE, 8'h10);
      wr(8'hAC, 8'h80);
      wait2;
      show(2'b01);
      wr(8'hB1, 8'h00);
      wait2;
      show(2'b10);
      $display("display test done");
    end
  endtask
  initial begin
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    reset_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_pins;
    t_mux;
    t_mem;
    t_rate;
    t_disp;
    summarize;
  end
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
endmodule
bind lcd_segment_frame_control lcd_segment_frame_control_assertions chk_u (.sys_clk,
  .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rdata, .seg_pin_lcd, .com_drive,
  .com_active, .drive_polarity, .frame_start);
